/* logic/srt_pkg.sv */
package srt_pkg;

   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CLKCTL = 8'h04;
   localparam logic [7:0] ADDR_INTEN = 8'h08;
   localparam logic [7:0] ADDR_CNTL = 8'h0C;
   localparam logic [7:0] ADDR_CNTH = 8'h10;
   localparam logic [7:0] ADDR_RLDL = 8'h14;
   localparam logic [7:0] ADDR_RLDH = 8'h18;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_HIGH_FLAG = 7;
   localparam int CTRL_LOW_FLAG = 6;
   localparam int CTRL_LOW_IRQ_EN = 5;
   localparam int CTRL_CAPTURE_EN = 4;
   localparam int CTRL_SPLIT = 3;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_EXT_SEL = 0;
   localparam int CLKCTL_HIGH_SEL = 5;
   localparam int CLKCTL_LOW_SEL = 4;
   localparam int INTEN_TIMER = 5;

   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   localparam int SYS_DIV = 12;

endpackage

/* logic/srt_timer.sv */
// The implementer's own choices: the APB slave port and the register offsets.
module srt_timer #(
   parameter int SYS_DIV = srt_pkg::SYS_DIV
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External oscillator divided by eight, asynchronous
   input wire logic extClkDiv8,
   // Interrupt request
   output logic timerIrq
);

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   // The prescaler counter is eight bits wide
   if (SYS_DIV < 2 || SYS_DIV > 255)
   begin : gBadDiv
      $error("SYS_DIV must lie between 2 and 255");
   end

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // Next value of an 8-bit auto-reload counter
   function automatic logic [7:0] byteNext(input logic [7:0] cnt,
                                           input logic [7:0] rld);
      byteNext = (cnt == srt_pkg::BYTE_MAX) ? rld : cnt + 8'h01;
   endfunction

   // Byte counter clock: system clock, or divided/external clock
   function automatic logic pickTick(input logic sysSel,
                                     input logic extSel,
                                     input logic divTick,
                                     input logic extTick);
      pickTick = sysSel | (extSel ? extTick : divTick);
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] cntLow_ff;
   logic [7:0] cntHigh_ff;
   logic [7:0] rldLow_ff;
   logic [7:0] rldHigh_ff;
   logic highFlag_ff;
   logic lowFlag_ff;
   logic lowIrqEn_ff;
   logic captureEn_ff;
   logic splitMode_ff;
   logic runCtl_ff;
   logic extClkSel_ff;
   logic highClkSel_ff;
   logic lowClkSel_ff;
   logic timerIrqEn_ff;
   logic [7:0] divCnt_ff;
   logic extSync1_ff;
   logic extSync2_ff;
   logic extSync3_ff;
   logic extLevel_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic timerIrq_ff;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Writes land only on the edge that completes the access
   wire accessDone = psel & penable & pready_ff;
   wire busWr = accessDone & pwrite;
   wire selCtrl = (paddr == srt_pkg::ADDR_CTRL);
   wire selClk = (paddr == srt_pkg::ADDR_CLKCTL);
   wire selInt = (paddr == srt_pkg::ADDR_INTEN);
   wire selCntL = (paddr == srt_pkg::ADDR_CNTL);
   wire selCntH = (paddr == srt_pkg::ADDR_CNTH);
   wire selRldL = (paddr == srt_pkg::ADDR_RLDL);
   wire selRldH = (paddr == srt_pkg::ADDR_RLDH);
   wire mapped = selCtrl | selClk | selInt | selCntL | selCntH |
                 selRldL | selRldH;
   wire wrCtrl = busWr & selCtrl;
   wire wrClk = busWr & selClk;
   wire wrInt = busWr & selInt;
   wire wrCntL = busWr & selCntL;
   wire wrCntH = busWr & selCntH;
   wire wrRldL = busWr & selRldL;
   wire wrRldH = busWr & selRldH;

   wire [7:0] ctrlView = {highFlag_ff, lowFlag_ff, lowIrqEn_ff,
                          captureEn_ff, splitMode_ff, runCtl_ff,
                          1'b0, extClkSel_ff};
   wire [7:0] clkView = {2'b00, highClkSel_ff, lowClkSel_ff, 4'h0};
   wire [7:0] intView = {2'b00, timerIrqEn_ff, 5'h00};
   // Unmapped offsets read as zero
   wire [7:0] rdByte = selCtrl ? ctrlView :
                       selClk ? clkView :
                       selInt ? intView :
                       selCntL ? cntLow_ff :
                       selCntH ? cntHigh_ff :
                       selRldL ? rldLow_ff :
                       selRldH ? rldHigh_ff : 8'h00;

   // ---------------------------------------------------------------
   // Clock sources
   // ---------------------------------------------------------------
   wire divTick = (divCnt_ff == 8'(SYS_DIV - 1));
   wire [7:0] nxt_divCnt = divTick ? 8'h00 : divCnt_ff + 8'h01;
   // Level accepted once second and third stages agree
   wire extAgree = (extSync2_ff == extSync3_ff);
   wire nxt_extLevel = extAgree ? extSync3_ff : extLevel_ff;
   // Rising edges drive counting, falling edges drive capture
   wire extRise = nxt_extLevel & ~extLevel_ff;
   wire extFall = ~nxt_extLevel & extLevel_ff;

   wire lowTick = captureEn_ff ?
                  (lowClkSel_ff | divTick) :
                  pickTick(lowClkSel_ff, extClkSel_ff,
                           divTick, extRise);
   wire highTick = pickTick(highClkSel_ff, extClkSel_ff,
                            divTick, extRise);

   // ---------------------------------------------------------------
   // Counting
   // ---------------------------------------------------------------
   // Two byte reads of the count are not atomic; a carry between them
   // can tear the word, so software should stop the timer first
   wire [15:0] cntWord = {cntHigh_ff, cntLow_ff};
   wire [15:0] rldWord = {rldHigh_ff, rldLow_ff};
   wire captureEvt = captureEn_ff & extFall;
   // Capture mode free-runs; the reload pair holds captures there
   wire [15:0] wrapWord = captureEn_ff ? 16'h0000 : rldWord;
   wire step16 = ~splitMode_ff & runCtl_ff & lowTick;
   wire wrap16 = step16 & (cntWord == srt_pkg::WORD_MAX);
   wire [15:0] inc16 = wrap16 ? wrapWord : cntWord + 16'h0001;
   wire stepLow = splitMode_ff & lowTick;
   wire stepHigh = splitMode_ff & runCtl_ff & highTick;
   wire wrapLowS = stepLow & (cntLow_ff == srt_pkg::BYTE_MAX);
   wire wrapHighS = stepHigh & (cntHigh_ff == srt_pkg::BYTE_MAX);
   wire wrapLow16 = step16 & (cntLow_ff == srt_pkg::BYTE_MAX);

   wire [7:0] cntLowRun = step16 ? inc16[7:0] :
                          stepLow ? byteNext(cntLow_ff, rldLow_ff) :
                          cntLow_ff;
   wire [7:0] cntHighRun = step16 ? inc16[15:8] :
                           stepHigh ? byteNext(cntHigh_ff, rldHigh_ff) :
                           cntHigh_ff;
   wire [7:0] nxt_cntLow = wrCntL ? pwdata[7:0] : cntLowRun;
   wire [7:0] nxt_cntHigh = wrCntH ? pwdata[7:0] : cntHighRun;

   // Capture wins over a software write to the reload pair
   wire [7:0] nxt_rldLow = captureEvt ? cntLow_ff :
                           wrRldL ? pwdata[7:0] : rldLow_ff;
   wire [7:0] nxt_rldHigh = captureEvt ? cntHigh_ff :
                            wrRldH ? pwdata[7:0] : rldHigh_ff;

   // ---------------------------------------------------------------
   // Flags and interrupt
   // ---------------------------------------------------------------
   // A capture also marks the high flag so software sees each edge
   wire setHigh = (wrap16 & ~captureEn_ff) | wrapHighS |
                  captureEvt;
   wire setLow = (wrapLow16 & ~captureEn_ff) | wrapLowS;
   // Hardware set wins over a software clear in the same cycle
   wire nxt_highFlag = setHigh |
                       (wrCtrl ? pwdata[srt_pkg::CTRL_HIGH_FLAG] :
                        highFlag_ff);
   wire nxt_lowFlag = setLow |
                      (wrCtrl ? pwdata[srt_pkg::CTRL_LOW_FLAG] :
                       lowFlag_ff);
   wire nxt_timerIrq = timerIrqEn_ff &
                       (highFlag_ff | (lowIrqEn_ff & lowFlag_ff));

   // ---------------------------------------------------------------
   // Sequential logic
   // ---------------------------------------------------------------
   // ---------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------
   // No reset: the pin level flushes through in three edges
   // Only the second stage reads the first
   always_ff @(posedge clk_sys)
   begin
      extSync1_ff <= extClkDiv8;
      extSync2_ff <= extSync1_ff;
      extSync3_ff <= extSync2_ff;
   end

   // ---------------------------------------------------------------
   // Counter, reload pair and flag registers
   // ---------------------------------------------------------------
   // Prescaler runs from reset so divided ticks stay evenly spaced
   // Request follows the flags one edge later
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         divCnt_ff <= 8'h00;
         extLevel_ff <= 1'b0;
         cntLow_ff <= srt_pkg::RST_BYTE;
         cntHigh_ff <= srt_pkg::RST_BYTE;
         rldLow_ff <= srt_pkg::RST_BYTE;
         rldHigh_ff <= srt_pkg::RST_BYTE;
         highFlag_ff <= 1'b0;
         lowFlag_ff <= 1'b0;
         timerIrq_ff <= 1'b0;
      end
      else
      begin
         divCnt_ff <= nxt_divCnt;
         extLevel_ff <= nxt_extLevel;
         cntLow_ff <= nxt_cntLow;
         cntHigh_ff <= nxt_cntHigh;
         rldLow_ff <= nxt_rldLow;
         rldHigh_ff <= nxt_rldHigh;
         highFlag_ff <= nxt_highFlag;
         lowFlag_ff <= nxt_lowFlag;
         timerIrq_ff <= nxt_timerIrq;
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   // Flags live in the counter block above
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         lowIrqEn_ff <= 1'b0;
         captureEn_ff <= 1'b0;
         splitMode_ff <= 1'b0;
         runCtl_ff <= 1'b0;
         extClkSel_ff <= 1'b0;
      end
      else if (wrCtrl)
      begin
         lowIrqEn_ff <= pwdata[srt_pkg::CTRL_LOW_IRQ_EN];
         captureEn_ff <= pwdata[srt_pkg::CTRL_CAPTURE_EN];
         splitMode_ff <= pwdata[srt_pkg::CTRL_SPLIT];
         runCtl_ff <= pwdata[srt_pkg::CTRL_RUN];
         extClkSel_ff <= pwdata[srt_pkg::CTRL_EXT_SEL];
      end
   end

   // ---------------------------------------------------------------
   // Clock control register
   // ---------------------------------------------------------------
   // Select bits take effect on the next tick
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         highClkSel_ff <= 1'b0;
         lowClkSel_ff <= 1'b0;
      end
      else if (wrClk)
      begin
         highClkSel_ff <= pwdata[srt_pkg::CLKCTL_HIGH_SEL];
         lowClkSel_ff <= pwdata[srt_pkg::CLKCTL_LOW_SEL];
      end
   end

   // ---------------------------------------------------------------
   // Interrupt enable register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         timerIrqEn_ff <= 1'b0;
      end
      else if (wrInt)
      begin
         timerIrqEn_ff <= pwdata[srt_pkg::INTEN_TIMER];
      end
   end

   // ---------------------------------------------------------------
   // APB answer: one wait state, then pready for one cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else
      begin
         // Read data reflects the registers as they stood in the access
         // cycle; unmapped offsets answer with pslverr and change nothing
         pready_ff <= psel & penable & ~pready_ff;
         pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
         prdata_ff <= {24'h00_0000, rdByte};
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Every output comes straight from a flop
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign timerIrq = timerIrq_ff;

endmodule

/* tb/srt_timer_checker.sv */
module srt_timer_checker #(
   parameter int SYS_DIV = 12
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Timer pins
   input wire logic extClkDiv8,
   input wire logic timerIrq
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic addrOk;
   assign addrOk = paddr[1:0] == 2'h0 && paddr <= srt_pkg::ADDR_RLDH;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   AST_RST_QUIET: assert property ($fell(sys_rst) |-> !timerIrq && !pready)
      else $error("output active after reset");
   AST_RDY_LAT: assert property (psel && $rose(penable) |=> pready)
      else $error("ready not one cycle into access");
   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_RDY_ACC: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   AST_ERR_MAP: assert property (pready |-> pslverr == !addrOk)
      else $error("error flag does not match map");
   AST_RD_BYTE: assert property (
      pready && !pwrite |-> prdata[31:8] == 24'h0 && (addrOk || !prdata))
      else $error("read data wider than a byte");
   AST_CTRL_B1: assert property (
      pready && !pwrite && paddr == srt_pkg::ADDR_CTRL |-> !prdata[1])
      else $error("control bit 1 not zero");
   AST_IRQ_OFF: assert property (
      pready && pwrite && paddr == srt_pkg::ADDR_INTEN &&
      !pwdata[srt_pkg::INTEN_TIMER] |-> ##2 !timerIrq)
      else $error("request with timer enable clear");
   AST_IRQ_HOLD: assert property (
      timerIrq |=> timerIrq || $past(pready && pwrite, 2))
      else $error("request dropped without a write");
endmodule

/* tb/srt_osc_model.sv */
module srt_osc_model #(
   parameter int HALF_NS = 200
) (
   // Divided oscillator
   output logic extClkDiv8
);
   timeunit 1ns;
   timeprecision 1ps;
   // Free running, far slower than the count clock, off the clock edges
   initial
   begin
      extClkDiv8 = 1'b0;
      #3;
      forever #(HALF_NS) extClkDiv8 = ~extClkDiv8;
   end
endmodule

/* tb/srt_timer_tb.sv */
module srt_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OSC_HALF = 200;
   typedef struct {
      logic [7:0] a;
      logic [7:0] d;
      logic [31:0] x;
      logic e;
   } srt_row_t;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic extClkDiv8;
   logic timerIrq;
   logic [31:0] rv;
   logic re;
   logic [15:0] capA;
   logic [15:0] capB;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   srt_row_t rows [8] = '{
      '{srt_pkg::ADDR_CLKCTL, 8'h30, 32'h30, 1'b0},
      '{srt_pkg::ADDR_INTEN, 8'h20, 32'h20, 1'b0},
      '{srt_pkg::ADDR_RLDL, 8'hA5, 32'hA5, 1'b0},
      '{srt_pkg::ADDR_RLDH, 8'h5A, 32'h5A, 1'b0},
      '{srt_pkg::ADDR_CNTL, 8'h3C, 32'h3C, 1'b0},
      '{srt_pkg::ADDR_CNTH, 8'hC3, 32'hC3, 1'b0},
      '{srt_pkg::ADDR_CTRL, 8'h03, 32'h01, 1'b0},
      '{8'h1C, 8'hFF, 32'h0, 1'b1}};

   srt_timer #(.SYS_DIV(srt_pkg::SYS_DIV)) srt_timer_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extClkDiv8(extClkDiv8), .timerIrq(timerIrq));
   srt_osc_model #(.HALF_NS(OSC_HALF)) srt_osc_model_inst (
      .extClkDiv8(extClkDiv8));

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] x);
      checks_done++;
      if (s !== x)
      begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, x, s);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      chk("ready", 32'(pready), 32'h1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask

   task automatic wirq(input int lim);
      int n;
      n = 0;
      repeat (3) @(posedge clk_sys);
      while (timerIrq !== 1'b1 && n < lim)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk("irq", 32'(timerIrq), 32'h1);
   endtask

   initial
   begin
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      foreach (rows[i])
      begin
         rd(rows[i].a);
         chk("reset", rv, 32'h0);
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk("rdback", rv, rows[i].x);
         chk("slverr", 32'(re), 32'(rows[i].e));
      end
      $display("done: registers");
      wr(srt_pkg::ADDR_CLKCTL, 8'h10);
      wr(srt_pkg::ADDR_RLDH, 8'hFF);
      wr(srt_pkg::ADDR_RLDL, 8'hF0);
      wr(srt_pkg::ADDR_CNTH, 8'hFF);
      wr(srt_pkg::ADDR_CNTL, 8'hF0);
      wr(srt_pkg::ADDR_CTRL, 8'h04);
      wirq(40);
      repeat (20) @(posedge clk_sys);
      chk("irqhold", 32'(timerIrq), 32'h1);
      rd(srt_pkg::ADDR_CTRL);
      chk("hflag", rv & 32'h80, 32'h80);
      rd(srt_pkg::ADDR_CNTH);
      chk("reload", rv, 32'hFF);
      wr(srt_pkg::ADDR_CTRL, 8'h00);
      // A wrap on the stopping edge sets the flag again; clear once more
      wr(srt_pkg::ADDR_CTRL, 8'h00);
      repeat (3) @(posedge clk_sys);
      chk("irqclr", 32'(timerIrq), 32'h0);
      wr(srt_pkg::ADDR_RLDH, 8'h00);
      wr(srt_pkg::ADDR_CNTH, 8'h00);
      wr(srt_pkg::ADDR_CNTL, 8'hF0);
      wr(srt_pkg::ADDR_CTRL, 8'h24);
      wirq(40);
      rd(srt_pkg::ADDR_CTRL);
      chk("lflag", rv, 32'h64);
      wr(srt_pkg::ADDR_CTRL, 8'h04);
      repeat (30) @(posedge clk_sys);
      chk("lmask", 32'(timerIrq), 32'h0);
      $display("done: sixteen bit");
      wr(srt_pkg::ADDR_CTRL, 8'h00);
      wr(srt_pkg::ADDR_CLKCTL, 8'h30);
      wr(srt_pkg::ADDR_RLDL, 8'hFE);
      wr(srt_pkg::ADDR_RLDH, 8'hFE);
      wr(srt_pkg::ADDR_CNTL, 8'hFE);
      wr(srt_pkg::ADDR_CNTH, 8'hFE);
      wr(srt_pkg::ADDR_CTRL, 8'h08);
      repeat (10) @(posedge clk_sys);
      rd(srt_pkg::ADDR_CTRL);
      chk("split", rv, 32'h48);
      rd(srt_pkg::ADDR_CNTH);
      chk("hstop", rv, 32'hFE);
      chk("noirq", 32'(timerIrq), 32'h0);
      wr(srt_pkg::ADDR_CTRL, 8'h28);
      wirq(10);
      wr(srt_pkg::ADDR_CTRL, 8'h0C);
      repeat (10) @(posedge clk_sys);
      rd(srt_pkg::ADDR_CTRL);
      chk("hrun", rv, 32'hCC);
      $display("done: split");
      wr(srt_pkg::ADDR_CTRL, 8'h00);
      wr(srt_pkg::ADDR_CLKCTL, 8'h00);
      wr(srt_pkg::ADDR_CNTL, 8'h00);
      wr(srt_pkg::ADDR_CTRL, 8'h04);
      repeat (10 * srt_pkg::SYS_DIV) @(posedge clk_sys);
      wr(srt_pkg::ADDR_CTRL, 8'h00);
      rd(srt_pkg::ADDR_CNTL);
      chk("div", 32'(rv >= 10 && rv <= 11), 32'h1);
      wr(srt_pkg::ADDR_CNTL, 8'h00);
      wr(srt_pkg::ADDR_CTRL, 8'h05);
      repeat (5 * OSC_HALF / 5) @(posedge clk_sys);
      wr(srt_pkg::ADDR_CTRL, 8'h01);
      rd(srt_pkg::ADDR_CNTL);
      chk("ext", 32'(rv >= 5 && rv <= 6), 32'h1);
      $display("done: clocks");
      wr(srt_pkg::ADDR_CLKCTL, 8'h10);
      wr(srt_pkg::ADDR_CTRL, 8'h14);
      wirq(60);
      rd(srt_pkg::ADDR_RLDL);
      capA[7:0] = rv[7:0];
      rd(srt_pkg::ADDR_RLDH);
      capA[15:8] = rv[7:0];
      wr(srt_pkg::ADDR_CTRL, 8'h14);
      wirq(60);
      rd(srt_pkg::ADDR_RLDL);
      capB[7:0] = rv[7:0];
      rd(srt_pkg::ADDR_RLDH);
      capB[15:8] = rv[7:0];
      chk("period", 32'(capB - capA), OSC_HALF / 5);
      wr(srt_pkg::ADDR_INTEN, 8'h00);
      repeat (3) @(posedge clk_sys);
      chk("ieoff", 32'(timerIrq), 32'h0);
      $display("done: capture");
      close_out();
   end
endmodule

bind srt_timer srt_timer_checker #(.SYS_DIV(SYS_DIV)) srt_timer_checker_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .extClkDiv8(extClkDiv8), .timerIrq(timerIrq));
